// [core/piar_pkg.sv]
/*
 * Package for the PHY identifier and auto-negotiation advertisement register bank.
 * Holds the register addresses, the advertisement field layout and its reset value,
 * the write mask and the request carrier.
 * Assumes the management frame engine delivers one decoded request per clock.
 */
package piar_pkg;

    localparam logic [4:0] ADDR_ID_HIGH = 5'h02;
    localparam logic [4:0] ADDR_ID_LOW = 5'h03;
    localparam logic [4:0] ADDR_ADVERT = 5'h04;

    localparam logic [4:0] SEL_IEEE_8023 = 5'h01;
    localparam logic [4:0] SEL_IEEE_8029 = 5'h02;
    localparam logic [4:0] SEL_RSVD_LOW = 5'h00;
    localparam logic [4:0] SEL_RSVD_HIGH = 5'h1F;

    // advertisement word, msb first
    typedef struct packed {
        logic nextPage;
        logic rsvd14;
        logic remoteFault;
        logic rsvd12;
        logic asymPause;
        logic pause;
        logic t4Ability;
        logic [3:0] ability;
        logic [4:0] selector;
    } piar_adv_t;

    localparam logic [15:0] ADV_RESET = 16'h0001;
    localparam logic [15:0] ADV_WRITE_MASK = 16'hBFFF;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } piar_req_t;

endpackage

// [core/piar_strap_capture.sv]
/*
 * Strap capture for the advertisement defaults.
 * Samples the pause strap and the four config_strap_pins levels at the first
 * clock edge after reset release and issues a single load pulse.
 * Assumes the strap levels are stable around reset release.
 */
`timescale 1ns/1ps
`default_nettype none

module piar_strap_capture (
    input wire logic clk,
    input wire logic resetn,
    input wire logic pauseStrap,
    input wire logic [3:0] config_strap_pins,
    output logic loadPulse_reg,
    output logic pauseVal_reg,
    output logic [3:0] abilityVal_reg
);

    logic done_reg;

    // caught by a clocked process after release, never by the reset itself
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            done_reg <= 1'b0;
            loadPulse_reg <= 1'b0;
            pauseVal_reg <= 1'b0;
            abilityVal_reg <= 4'h0;
        end else begin
            done_reg <= 1'b1;
            loadPulse_reg <= !done_reg;
            if (!done_reg) begin
                pauseVal_reg <= pauseStrap;
                abilityVal_reg <= config_strap_pins;
            end
        end
    end

endmodule // piar_strap_capture

`default_nettype wire

// [core/piar_regs.sv]
/*
 * PHY identifier registers (addresses 2 and 3) and auto-negotiation
 * advertisement register (address 4) of the management register set.
 * Assumes a frame engine presents decoded read and write requests, one per
 * clock, synchronous to clk; other addresses are served elsewhere.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R1] address 2 returns identifier bits 3..18
// [R2] address 3 bits 15:10 return identifier 19..24
// [R3] address 3 bits 9:4 return model number
// [R4] address 3 bits 3:0 return revision
// [R5] next page bit read/write, resets 0
// [R6] remote fault bit read/write, resets 0
// [R7] asymmetric pause bit read/write, resets 0
// [R8] pause bit read/write, default from strap
// [R9] 100BASE-T4 bit writable, resets 0
// [R10] four ability bits read/write, strap defaults
// [R11] selector read/write, resets to 802.3 code
// [R12] software avoids reserved selector codes
// [R13] writes to read-only bits are ignored
module piar_regs #(
    parameter logic [15:0] OUI_MID = 16'h1234, // arbitrary value
    parameter logic [5:0] OUI_TOP = 6'h2A, // arbitrary value
    parameter logic [5:0] MODEL_NUM = 6'h15, // arbitrary value
    parameter logic [3:0] REVISION_NUM = 4'h1 // arbitrary value
) (
    input wire logic clk,
    input wire logic resetn,
    input wire piar_pkg::piar_req_t mgmtReq,
    input wire logic pauseStrap,
    input wire logic [3:0] config_strap_pins,
    output logic [15:0] rdData_reg,
    output logic rdValid_reg,
    output logic rdHit_reg,
    output piar_pkg::piar_adv_t advWord_reg
);

    ////////////////////////////////////////////////////////////////////////
    // strap defaults

    logic loadPulse;
    logic pauseVal;
    logic [3:0] abilityVal;

    piar_strap_capture strapCapture (
        .clk(clk),
        .resetn(resetn),
        .pauseStrap(pauseStrap),
        .config_strap_pins(config_strap_pins),
        .loadPulse_reg(loadPulse),
        .pauseVal_reg(pauseVal),
        .abilityVal_reg(abilityVal)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode

    function automatic logic addrInBank(input logic [4:0] a);
        addrInBank = (a == piar_pkg::ADDR_ID_HIGH) || (a == piar_pkg::ADDR_ID_LOW)
            || (a == piar_pkg::ADDR_ADVERT);
    endfunction

    wire logic [15:0] idHighWord = OUI_MID; // [R1]
    wire logic [15:0] idLowWord = {OUI_TOP, MODEL_NUM, REVISION_NUM}; // [R2] [R3] [R4]
    wire logic readHit = mgmtReq.rd && addrInBank(mgmtReq.addr);
    wire logic advWrite = mgmtReq.wr && (mgmtReq.addr == piar_pkg::ADDR_ADVERT);
    wire logic [15:0] readMux =
        (mgmtReq.addr == piar_pkg::ADDR_ID_HIGH) ? idHighWord :
        (mgmtReq.addr == piar_pkg::ADDR_ID_LOW) ? idLowWord :
        (mgmtReq.addr == piar_pkg::ADDR_ADVERT) ? 16'(advWord_reg) : 16'h0000;

    // id writes never reach storage; bit 14 masked off
    wire logic [15:0] advWritten = mgmtReq.wdata & piar_pkg::ADV_WRITE_MASK; // [R13]

    piar_pkg::piar_adv_t advStrapped;
    piar_pkg::piar_adv_t advNext;

    always_comb begin
        advStrapped = advWord_reg;
        advStrapped.pause = pauseVal; // [R8]
        advStrapped.ability = abilityVal; // [R10]
    end

    // strap load wins over a colliding write
    assign advNext = loadPulse ? advStrapped :
        advWrite ? piar_pkg::piar_adv_t'(advWritten) : advWord_reg; // [R5] [R6] [R7] [R9] [R11]

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            advWord_reg <= piar_pkg::piar_adv_t'(piar_pkg::ADV_RESET); // [R5] [R6] [R7] [R9] [R11]
        end else begin
            advWord_reg <= advNext;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdData_reg <= 16'h0000;
            rdValid_reg <= 1'b0;
            rdHit_reg <= 1'b0;
        end else begin
            rdValid_reg <= mgmtReq.rd;
            rdHit_reg <= readHit;
            rdData_reg <= mgmtReq.rd ? readMux : rdData_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    wire logic rdHigh = mgmtReq.rd && (mgmtReq.addr == piar_pkg::ADDR_ID_HIGH);
    wire logic rdLow = mgmtReq.rd && (mgmtReq.addr == piar_pkg::ADDR_ID_LOW);
    wire logic rdAdv = mgmtReq.rd && (mgmtReq.addr == piar_pkg::ADDR_ADVERT);
    wire logic idWrite = mgmtReq.wr && (mgmtReq.addr == piar_pkg::ADDR_ID_HIGH
        || mgmtReq.addr == piar_pkg::ADDR_ID_LOW);
    wire logic plainWrite = advWrite && !loadPulse;

    ////////////////////////////////////////////////////////////////////////
    // read path checks

    id_high_read_a: assert property ( // [R1]
        rdHigh |=> rdValid_reg && rdHit_reg && rdData_reg == OUI_MID)
        else $error("id high read wrong");
    id_low_valid_a: assert property ( // [R2]
        rdLow |=> rdValid_reg && rdHit_reg)
        else $error("id low read not answered");
    id_top_bits_a: assert property ( // [R2]
        rdLow |=> rdData_reg[15:10] == OUI_TOP)
        else $error("id top bits wrong");
    model_field_a: assert property ( // [R3]
        rdLow |=> rdData_reg[9:4] == MODEL_NUM)
        else $error("model field wrong");
    revision_field_a: assert property ( // [R4]
        rdLow |=> rdData_reg[3:0] == REVISION_NUM)
        else $error("revision field wrong");
    adv_read_a: assert property ( // [R5] [R6] [R7] [R9] [R11]
        rdAdv |=> rdValid_reg && rdHit_reg && rdData_reg == $past(16'(advWord_reg)))
        else $error("advert read wrong");
    miss_read_a: assert property ( // [R13]
        mgmtReq.rd && !readHit |=> rdValid_reg && !rdHit_reg && rdData_reg == 16'h0000)
        else $error("miss read wrong");

    ////////////////////////////////////////////////////////////////////////
    // write path checks

    next_page_wr_a: assert property ( // [R5]
        plainWrite |=> advWord_reg.nextPage == $past(mgmtReq.wdata[15]))
        else $error("next page not written");
    remote_fault_wr_a: assert property ( // [R6]
        plainWrite |=> advWord_reg.remoteFault == $past(mgmtReq.wdata[13]))
        else $error("remote fault not written");
    asym_pause_wr_a: assert property ( // [R7]
        plainWrite |=> advWord_reg.asymPause == $past(mgmtReq.wdata[11]))
        else $error("asym pause not written");
    pause_wr_a: assert property ( // [R8]
        plainWrite |=> advWord_reg.pause == $past(mgmtReq.wdata[10]))
        else $error("pause not written");
    t4_write_a: assert property ( // [R9]
        plainWrite |=> advWord_reg.t4Ability == $past(mgmtReq.wdata[9]))
        else $error("t4 bit not written");
    ability_wr_a: assert property ( // [R10]
        plainWrite |=> advWord_reg.ability == $past(mgmtReq.wdata[8:5]))
        else $error("ability bits not written");
    selector_wr_a: assert property ( // [R11]
        plainWrite |=> advWord_reg.selector == $past(mgmtReq.wdata[4:0]))
        else $error("selector not written");
    rsvd_bit_ro_a: assert property ( // [R13]
        advWord_reg.rsvd14 == 1'b0)
        else $error("reserved bit 14 set");
    bit14_write_a: assert property ( // [R13]
        plainWrite && mgmtReq.wdata[14] |=> !advWord_reg.rsvd14)
        else $error("bit 14 took a write");
    id_write_ro_a: assert property ( // [R13]
        idWrite && !loadPulse |=> $stable(advWord_reg))
        else $error("id write leaked into advert");
    selector_hold_a: assert property ( // [R13]
        !advWrite && !loadPulse |=> $stable(advWord_reg))
        else $error("advert changed without write");

    ////////////////////////////////////////////////////////////////////////
    // reset and strap checks

    next_page_rst_a: assert property ( // [R5]
        $rose(resetn) |-> !advWord_reg.nextPage)
        else $error("next page reset wrong");
    remote_fault_rst_a: assert property ( // [R6]
        $rose(resetn) |-> !advWord_reg.remoteFault)
        else $error("remote fault reset wrong");
    asym_pause_rst_a: assert property ( // [R7]
        $rose(resetn) |-> !advWord_reg.asymPause)
        else $error("asym pause reset wrong");
    t4_reset_a: assert property ( // [R9]
        $rose(resetn) |-> !advWord_reg.t4Ability)
        else $error("t4 bit reset wrong");
    selector_rst_a: assert property ( // [R11]
        $rose(resetn) |-> advWord_reg.selector == piar_pkg::SEL_IEEE_8023)
        else $error("selector reset wrong");
    strap_load_time_a: assert property ( // [R8] [R10]
        $rose(resetn) |-> ##1 loadPulse)
        else $error("strap load not issued");
    pause_strap_a: assert property ( // [R8]
        loadPulse |=> advWord_reg.pause == $past(pauseVal))
        else $error("pause strap not loaded");
    ability_strap_a: assert property ( // [R10]
        loadPulse |=> (advWord_reg.ability == $past(abilityVal)) ##0 (!loadPulse)[*3])
        else $error("ability straps not loaded");

    ////////////////////////////////////////////////////////////////////////
    // scenario covers

    id_read_c: cover property (rdHigh ##[1:2] rdLow);
    adv_write_read_c: cover property (plainWrite ##[1:2] rdAdv);
    strap_load_c: cover property (loadPulse ##1 advWord_reg.pause);
    miss_read_c: cover property (mgmtReq.rd && !readHit);
    id_write_c: cover property (idWrite ##[1:2] rdHigh);

endmodule // piar_regs

`default_nettype wire

// [verif/piar_mgmt_model.sv]
/* management master model: single-word reads and writes on the request port.
   assumes requests launch 1 ns after the rising edge of clk. */
`timescale 1ns/1ps
`default_nettype none
module piar_mgmt_model (
    input wire logic clk,
    input wire logic [15:0] rdData,
    input wire logic rdValid,
    input wire logic rdHit,
    output var piar_pkg::piar_req_t mgmtReq
);
    initial mgmtReq = '0;
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        // reserved selector codes never leave software
        if (a == piar_pkg::ADDR_ADVERT && (d[4:0] == piar_pkg::SEL_RSVD_LOW ||
            d[4:0] == piar_pkg::SEL_RSVD_HIGH)) begin
            d[4:0] = piar_pkg::SEL_IEEE_8023;
        end
        @(posedge clk) #1;
        mgmtReq = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk) #1;
        mgmtReq = '0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v, output logic h);
        @(posedge clk) #1;
        mgmtReq = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(posedge clk) #1;
        d = rdData;
        v = rdValid;
        h = rdHit;
        mgmtReq = '0;
    endtask
endmodule // piar_mgmt_model
`default_nettype wire

// [verif/tb.sv]
/* testbench for the identifier and advertisement register bank.
   assumes the management model in piar_mgmt_model drives all requests. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [15:0] OUI_MID = 16'h1234; // arbitrary value
    localparam logic [5:0] OUI_TOP = 6'h2A; // arbitrary value
    localparam logic [5:0] MODEL_NUM = 6'h15; // arbitrary value
    localparam logic [3:0] REVISION_NUM = 4'h1; // arbitrary value
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic pauseStrap = 1'b1;
    logic [3:0] strapPins = 4'hA;
    piar_pkg::piar_req_t mgmtReq;
    logic [15:0] rdData;
    logic rdValid;
    logic rdHit;
    piar_pkg::piar_adv_t advWord;
    logic [15:0] advReset;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    always #2.5 clk = ~clk;
    piar_regs #(.OUI_MID(OUI_MID), .OUI_TOP(OUI_TOP), .MODEL_NUM(MODEL_NUM),
        .REVISION_NUM(REVISION_NUM)) dut (.clk(clk), .resetn(resetn), .mgmtReq(mgmtReq),
        .pauseStrap(pauseStrap), .config_strap_pins(strapPins), .rdData_reg(rdData),
        .rdValid_reg(rdValid), .rdHit_reg(rdHit), .advWord_reg(advWord));
    piar_mgmt_model mgr (.clk(clk), .rdData(rdData), .rdValid(rdValid), .rdHit(rdHit),
        .mgmtReq(mgmtReq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp, input logic hit);
        logic [15:0] d;
        logic v;
        logic h;
        mgr.rd(a, d, v, h);
        chk({15'h0000, v}, 16'h0001);
        chk({15'h0000, h}, {15'h0000, hit});
        chk(d, exp);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        advReset = {5'h00, pauseStrap, 1'b0, strapPins, piar_pkg::SEL_IEEE_8023};
        repeat (5) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (3) @(posedge clk);
        chk(advWord, advReset);
        rd_chk(piar_pkg::ADDR_ADVERT, advReset, 1'b1);
        rd_chk(piar_pkg::ADDR_ID_HIGH, OUI_MID, 1'b1);
        rd_chk(piar_pkg::ADDR_ID_LOW, {OUI_TOP, MODEL_NUM, REVISION_NUM}, 1'b1);
        // identifier writes must leave the words untouched
        mgr.wr(piar_pkg::ADDR_ID_HIGH, 16'hFFFF);
        mgr.wr(piar_pkg::ADDR_ID_LOW, 16'h0000);
        rd_chk(piar_pkg::ADDR_ID_HIGH, OUI_MID, 1'b1);
        rd_chk(piar_pkg::ADDR_ID_LOW, {OUI_TOP, MODEL_NUM, REVISION_NUM}, 1'b1);
        // all writable bits set, 802.9 selector, bit 14 refused
        mgr.wr(piar_pkg::ADDR_ADVERT, 16'hFFE2);
        chk(advWord, 16'hBFE2);
        rd_chk(piar_pkg::ADDR_ADVERT, 16'hBFE2, 1'b1);
        // reserved selector is replaced by software before it is sent
        mgr.wr(piar_pkg::ADDR_ADVERT, 16'hFFFF);
        rd_chk(piar_pkg::ADDR_ADVERT, 16'hBFE1, 1'b1);
        mgr.wr(piar_pkg::ADDR_ADVERT, 16'h0001);
        rd_chk(piar_pkg::ADDR_ADVERT, 16'h0001, 1'b1);
        rd_chk(5'h05, 16'h0000, 1'b0);
        // second reset with other strap levels
        pauseStrap = 1'b0;
        strapPins = 4'h5;
        resetn = 1'b0;
        advReset = {5'h00, pauseStrap, 1'b0, strapPins, piar_pkg::SEL_IEEE_8023};
        repeat (5) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (3) @(posedge clk);
        chk(advWord, advReset);
        rd_chk(piar_pkg::ADDR_ADVERT, advReset, 1'b1);
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
